// ==== adc_model.sv ====
// converter model: answers the selected channel, toggles a pattern while idle
`timescale 1ns/1ns
module adc_model
    import pwr_eng_pkg::*;
(
    // clock, reset
    input  wire logic              core_clk_in,
    input  wire logic              arst_n_in,
    // sample values and per-round step
    input  wire logic [DATA_W-1:0] shunt_val_in,
    input  wire logic [DATA_W-1:0] bus_val_in,
    input  wire logic [DATA_W-1:0] temp_val_in,
    input  wire logic [DATA_W-1:0] step_in,
    // converter side
    input  wire logic [1:0]        adc_chan_in,
    input  wire logic              adc_run_in,
    output logic [DATA_W-1:0]      adc_data_out
);
    logic [1:0]        prev_chan_ff;
    logic [7:0]        rnd_ff;
    logic [DATA_W-1:0] noise_ff;
    logic [DATA_W-1:0] base;

    ////////////////////////////////////////////////////////////////////////////////
    // round count, advanced when the sequence returns to shunt
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_chan_ff <= 2'h0;
            rnd_ff       <= 8'h00;
            noise_ff     <= 20'hAAAAA;
        end else begin
            prev_chan_ff <= adc_chan_in;
            noise_ff     <= ~noise_ff;
            if (!adc_run_in) begin
                rnd_ff <= 8'h00;
            end else if (adc_chan_in != prev_chan_ff && adc_chan_in == CH_SHUNT) begin
                rnd_ff <= rnd_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // only the selected channel reaches the data lines; odd rounds add the step
    assign base = (adc_chan_in == CH_SHUNT) ? shunt_val_in :
                  (adc_chan_in == CH_BUS) ? bus_val_in : temp_val_in;
    assign adc_data_out = adc_run_in ? base + (rnd_ff[0] ? step_in : '0) : noise_ff;
endmodule

// ==== avg_acc_if.sv ====
// carrier between the engine and its averaging accumulator store
`timescale 1ns/1ns
interface avg_acc_if #(
    parameter int DW = 20,
    parameter int AW = 30
);
    logic          add_en;
    logic          clr;
    logic [1:0]    chan;
    logic [DW-1:0] value;
    logic [AW-1:0] sum_cur;
    logic [AW-1:0] sum_bus;
    logic [AW-1:0] sum_tmp;

    modport engine (output add_en, clr, chan, value, input sum_cur, sum_bus, sum_tmp);
    modport store  (input add_en, clr, chan, value, output sum_cur, sum_bus, sum_tmp);
endinterface

// ==== avg_acc_store.sv ====
// per-quantity averaging accumulators with registered sums
`timescale 1ns/1ns
module avg_acc_store
    import pwr_eng_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = SUM_W
) (
    // clock, reset, enable
    input  wire logic   core_clk_in,
    input  wire logic   arst_n_in,
    input  wire logic   ce_in,
    // engine side
    avg_acc_if.store    acc
);
    logic [AW-1:0] sum_ff [3];
    logic [AW-1:0] ext_w;

    // sign-extend the new sample to the accumulator width
    assign ext_w = {{(AW-DW){acc.value[DW-1]}}, acc.value};

    // clear after publish; a sample arriving with the clear starts the new sum
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < 3; i++) begin
                sum_ff[i] <= '0;
            end
        end else if (ce_in) begin
            for (int i = 0; i < 3; i++) begin
                if (acc.add_en && (acc.chan == 2'(i))) begin
                    sum_ff[i] <= acc.clr ? ext_w : AW'(sum_ff[i] + ext_w); // R6
                end else if (acc.clr) begin
                    sum_ff[i] <= '0;
                end
            end
        end
    end

    // sums out to the engine
    assign acc.sum_cur = sum_ff[0];
    assign acc.sum_bus = sum_ff[1];
    assign acc.sum_tmp = sum_ff[2];
endmodule

// ==== power_energy_calc_engine.sv ====
// measurement sequencer and current, power, energy and charge engine
`timescale 1ns/1ns
// Contract
// [R1] shunt result updates current and charge
// [R2] bus result updates power and energy
// [R3] power uses latest current, never waits
// [R4] zero scaling constant zeroes power, energy, charge
// [R5] average of one writes outputs directly
// [R6] averaging sums samples per quantity
// [R7] after last sample publish averages and power
// [R8] energy and charge accumulate every conversion
// [R9] calculation never lengthens the sequence
// [R10] one shared converter, one channel at a time
// [R11] continuous or triggered operation
// [R12] conversion time code selects time
// [R13] outputs change as a whole
module power_energy_calc_engine
    import pwr_eng_pkg::*;
#(
    parameter int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS
) (
    // clock, reset, enable
    input  wire logic              core_clk_in,
    input  wire logic              arst_n_in,
    input  wire logic              ce_in,
    // configuration
    input  wire logic              cont_mode_in,
    input  wire logic              trig_in,
    input  wire logic [2:0]        chan_en_in,
    input  wire logic [2:0]        ct_shunt_in,
    input  wire logic [2:0]        ct_bus_in,
    input  wire logic [2:0]        ct_temp_in,
    input  wire logic [3:0]        avg_log2_in,
    input  wire logic [CAL_W-1:0]  shunt_cal_in,
    // shared converter
    input  wire logic [DATA_W-1:0] adc_data_in,
    output logic [1:0]             adc_chan_out,
    output logic                   adc_run_out,
    // results
    output logic [DATA_W-1:0]      current_out,
    output logic [DATA_W-1:0]      bus_out,
    output logic [DATA_W-1:0]      temp_out,
    output logic [POW_W-1:0]       power_out,
    output logic [ACCU_W-1:0]      energy_out,
    output logic [ACCU_W-1:0]      charge_out,
    output logic                   ready_out
);
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [TMR_W-1:0] ct_cycles(input logic [2:0] code);
        return TMR_W'(CT_US[code] * CYC_PER_US);
    endfunction

    function automatic logic [POW_W-1:0] mul_pow(input logic [DATA_W-1:0] cur,
                                                 input logic [DATA_W-1:0] bus);
        return POW_W'($signed(cur) * $signed({1'b0, bus}));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    seq_state_type        state_ff, nxt_state;
    logic [1:0]           chan_ff, nxt_chan;
    logic [TMR_W-1:0]     tmr_ff, nxt_tmr;
    logic [ROUND_W-1:0]   rounds_ff, nxt_rounds, avg_last;
    logic [3:0]           avg_sh;
    logic [1:0]           first_ch, next_ch, load_ch;
    logic [2:0]           load_code, cur_code;
    logic                 start, capture, is_last, seq_end, go_on, averaging, load;

    // channel order and conversion timing decode
    assign avg_sh    = (avg_log2_in > 4'(AVG_LOG2_MAX)) ? 4'(AVG_LOG2_MAX) : avg_log2_in;
    assign averaging = (avg_sh != 4'h0);
    assign avg_last  = ROUND_W'((ROUND_W'(1) << avg_sh) - ROUND_W'(1));
    assign first_ch  = find_chan(CH_SHUNT, chan_en_in);
    assign next_ch   = find_chan(2'(chan_ff + 2'h1), chan_en_in);
    assign is_last   = (next_ch == CH_NONE);
    assign seq_end   = is_last && (rounds_ff == avg_last);
    assign start     = (state_ff == ST_IDLE) && (first_ch != CH_NONE)
                       && (cont_mode_in || trig_in); // R11
    assign capture   = (state_ff == ST_CONV) && (tmr_ff == '0);
    assign go_on     = (!seq_end || cont_mode_in) && (first_ch != CH_NONE); // R11
    assign load_ch   = (start || is_last) ? first_ch : next_ch;
    assign load      = start || (capture && go_on);
    assign load_code = (load_ch == CH_SHUNT) ? ct_shunt_in :
                       (load_ch == CH_BUS) ? ct_bus_in : ct_temp_in;
    assign cur_code  = (chan_ff == CH_SHUNT) ? ct_shunt_in :
                       (chan_ff == CH_BUS) ? ct_bus_in : ct_temp_in;

    // next sequencer state; the next channel is loaded in the capture cycle
    assign nxt_state  = load ? ST_CONV : (capture ? ST_IDLE : state_ff); // R9
    assign nxt_chan   = load ? load_ch : chan_ff;
    assign nxt_tmr    = load ? TMR_W'(ct_cycles(load_code) - TMR_W'(1)) // R12
                             : (capture ? tmr_ff : TMR_W'(tmr_ff - TMR_W'(1)));
    assign nxt_rounds = start ? '0 : ((capture && is_last) ?
                        (seq_end ? '0 : ROUND_W'(rounds_ff + ROUND_W'(1))) : rounds_ff);

    // sequencer registers
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff  <= ST_IDLE;
            chan_ff   <= CH_SHUNT;
            tmr_ff    <= '0;
            rounds_ff <= '0;
        end else if (ce_in) begin
            case (state_ff)
                ST_IDLE: state_ff <= nxt_state;
                ST_CONV: state_ff <= nxt_state;
                default: state_ff <= ST_IDLE;
            endcase
            chan_ff   <= nxt_chan;
            tmr_ff    <= nxt_tmr;
            rounds_ff <= nxt_rounds;
        end
    end

    // one channel on the converter at a time
    assign adc_run_out  = (state_ff == ST_CONV); // R10
    assign adc_chan_out = chan_ff;

    ////////////////////////////////////////////////////////////////////////////
    // calculation stage, runs beside the next conversion
    logic                 s1_vld_ff, s1_end_ff, pub_ff;
    logic [1:0]           s1_ch_ff;
    logic [DATA_W-1:0]    s1_data_ff, last_cur_ff;
    logic signed [DATA_W+CAL_W:0] cur_prod;
    logic [DATA_W-1:0]    cur_w, avg_cur, avg_bus, avg_tmp;
    logic [POW_W-1:0]     pow_w, avg_pow;
    logic                 cal_zero, sh_upd, bus_upd, tmp_upd, direct;

    avg_acc_if #(.DW(DATA_W), .AW(SUM_W)) acc ();

    avg_acc_store #(.DW(DATA_W), .AW(SUM_W)) avg_acc_store_inst (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .ce_in       (ce_in),
        .acc         (acc.store)
    );

    // derived quantities and update strobes
    assign cal_zero = (shunt_cal_in == '0);
    assign cur_prod = $signed(s1_data_ff) * $signed({1'b0, shunt_cal_in});
    assign cur_w    = DATA_W'(cur_prod >>> CAL_SHIFT);
    assign pow_w    = mul_pow(last_cur_ff, s1_data_ff); // R3
    assign direct   = s1_vld_ff && !averaging; // R5
    assign sh_upd   = s1_vld_ff && (s1_ch_ff == CH_SHUNT);
    assign bus_upd  = s1_vld_ff && (s1_ch_ff == CH_BUS);
    assign tmp_upd  = s1_vld_ff && (s1_ch_ff == CH_TEMP);

    // averaged results from the accumulator sums
    assign avg_cur = DATA_W'($signed(acc.sum_cur) >>> avg_sh); // R7
    assign avg_bus = DATA_W'($signed(acc.sum_bus) >>> avg_sh);
    assign avg_tmp = DATA_W'($signed(acc.sum_tmp) >>> avg_sh);
    assign avg_pow = mul_pow(avg_cur, avg_bus); // R7

    // accumulator feed
    assign acc.add_en = s1_vld_ff && averaging; // R6
    assign acc.clr    = pub_ff;
    assign acc.chan   = s1_ch_ff;
    assign acc.value  = (s1_ch_ff == CH_SHUNT) ? cur_w : s1_data_ff;

    // capture and pipeline registers
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_vld_ff   <= 1'b0;
            s1_end_ff   <= 1'b0;
            s1_ch_ff    <= CH_SHUNT;
            s1_data_ff  <= '0;
            pub_ff      <= 1'b0;
            last_cur_ff <= '0;
        end else if (ce_in) begin
            s1_vld_ff  <= capture;
            s1_end_ff  <= seq_end;
            s1_ch_ff   <= chan_ff;
            s1_data_ff <= capture ? adc_data_in : s1_data_ff;
            pub_ff     <= s1_vld_ff && s1_end_ff && averaging;
            if (sh_upd) begin
                last_cur_ff <= cur_w; // R1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result registers, each written in one edge
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            current_out <= '0;
            bus_out     <= '0;
            temp_out    <= '0;
            power_out   <= '0;
            energy_out  <= '0;
            charge_out  <= '0;
            ready_out   <= 1'b0;
        end else if (ce_in) begin
            if (pub_ff) begin
                current_out <= avg_cur; // R13
                bus_out     <= avg_bus;
                temp_out    <= avg_tmp;
                power_out   <= cal_zero ? '0 : avg_pow;
            end else begin
                current_out <= (direct && sh_upd) ? cur_w : current_out;
                bus_out     <= (direct && bus_upd) ? s1_data_ff : bus_out;
                temp_out    <= (direct && tmp_upd) ? s1_data_ff : temp_out;
                power_out   <= cal_zero ? '0 : ((direct && bus_upd) ? pow_w : power_out); // R4
            end
            // no averaging on the accumulators
            if (cal_zero) begin
                energy_out <= '0; // R4
                charge_out <= '0;
            end else begin
                energy_out <= bus_upd ? ACCU_W'(energy_out + {{(ACCU_W-POW_W){pow_w[POW_W-1]}},
                                        pow_w}) : energy_out; // R2 R8
                charge_out <= sh_upd ? ACCU_W'(charge_out + {{(ACCU_W-DATA_W){cur_w[DATA_W-1]}},
                                        cur_w}) : charge_out; // R1 R8
            end
            // completion set wins over trigger clear
            ready_out <= (s1_vld_ff && s1_end_ff && !averaging) || pub_ff
                         || (ready_out && !trig_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [TMR_W-1:0] conv_age_ff;

    // ce cycles spent on the present channel
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conv_age_ff <= '0;
        end else if (ce_in) begin
            conv_age_ff <= load ? '0 : TMR_W'(conv_age_ff + TMR_W'(1));
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    cal_zero_a: assert property (ce_in && cal_zero |=> // R4
        power_out == '0 && energy_out == '0 && charge_out == '0)
        else $error("results not zero with zero scaling constant");
    charge_step_a: assert property (ce_in && sh_upd && !cal_zero |=> // R1
        charge_out == ACCU_W'($past(charge_out) + ACCU_W'($signed($past(cur_w)))))
        else $error("charge not stepped by current");
    energy_step_a: assert property (ce_in && bus_upd && !cal_zero |=> // R2
        energy_out == ACCU_W'($past(energy_out)
                      + ACCU_W'($signed(mul_pow($past(last_cur_ff), $past(s1_data_ff))))))
        else $error("energy not stepped by power");
    power_keeps_cur_a: assert property (ce_in && bus_upd |=> $stable(last_cur_ff)) // R3
        else $error("bus result disturbed the stored current");
    one_channel_a: assert property (adc_run_out |-> adc_chan_out != CH_NONE) // R10
        else $error("converter running with no channel");
    direct_temp_a: assert property (ce_in && direct && tmp_upd |=> // R5
        temp_out == $past(s1_data_ff))
        else $error("temperature not written directly");
    avg_hold_a: assert property (ce_in && s1_vld_ff && averaging && !s1_end_ff |=> // R6
        $stable(current_out) && $stable(bus_out) && $stable(temp_out))
        else $error("outputs moved before averaging finished");
    publish_a: assert property (ce_in && pub_ff && !cal_zero |=> // R7
        current_out == $past(avg_cur) && power_out == $past(avg_pow))
        else $error("averaged results not published");
    no_gap_a: assert property (ce_in && capture && go_on |=> adc_run_out) // R9
        else $error("conversion sequence stalled by calculation");
    trig_idle_a: assert property (ce_in && state_ff == ST_IDLE && !cont_mode_in // R11
        && !trig_in |=> state_ff == ST_IDLE)
        else $error("conversion began without trigger");
    conv_time_a: assert property (ce_in && capture |-> // R12
        conv_age_ff == TMR_W'(ct_cycles(cur_code) - TMR_W'(1)))
        else $error("conversion time differs from code");

    shunt_seen_c: cover property (ce_in && sh_upd && !cal_zero);
    publish_seen_c: cover property (ce_in && pub_ff);
    trig_done_c: cover property (ce_in && capture && !go_on ##1 state_ff == ST_IDLE);
endmodule

// ==== power_energy_calc_engine_tb.sv ====
// self-checking bench of the measurement and calculation engine
`timescale 1ns/1ns
module power_energy_calc_engine_tb
    import pwr_eng_pkg::*;
;
    logic              clk, arst_n, ce, cont, trig;
    logic [2:0]        chan_en, ct_sh, ct_bus, ct_tmp;
    logic [3:0]        avg;
    logic [CAL_W-1:0]  cal;
    logic [DATA_W-1:0] shunt_v, bus_v, temp_v, step_v, adc_data, cur, rail_v, temp;
    logic [1:0]        adc_chan;
    logic              adc_run, ready;
    logic [POW_W-1:0]  pow;
    logic [ACCU_W-1:0] energy, charge;
    logic [63:0]       exp_e, exp_q;
    int                error_cnt, n_compared, cyc_cnt;

    power_energy_calc_engine #(.CYC_PER_US(1)) power_energy_calc_engine_inst (
        .core_clk_in(clk), .arst_n_in(arst_n), .ce_in(ce), .cont_mode_in(cont),
        .trig_in(trig), .chan_en_in(chan_en), .ct_shunt_in(ct_sh), .ct_bus_in(ct_bus),
        .ct_temp_in(ct_tmp), .avg_log2_in(avg), .shunt_cal_in(cal), .adc_data_in(adc_data),
        .adc_chan_out(adc_chan), .adc_run_out(adc_run), .current_out(cur), .bus_out(rail_v),
        .temp_out(temp), .power_out(pow), .energy_out(energy), .charge_out(charge),
        .ready_out(ready));

    adc_model adc_model_inst (
        .core_clk_in(clk), .arst_n_in(arst_n), .shunt_val_in(shunt_v), .bus_val_in(bus_v),
        .temp_val_in(temp_v), .step_in(step_v), .adc_chan_in(adc_chan), .adc_run_in(adc_run),
        .adc_data_out(adc_data));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        exp_e = '0;
        exp_q = '0;
        @(posedge clk);
    endtask

    task automatic seq_start();
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        for (int k = 0; k < 5 && !adc_run; k++) @(posedge clk);
    endtask

    task automatic seq_end();
        for (int k = 0; k < 20000 && adc_run; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk(64'(ready), 64'h1, "ready");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_vals();
        chk(64'(adc_run), 64'h0, "run after reset");
        chk(64'(cur), 64'h0, "current after reset");
        chk(64'(energy), 64'h0, "energy after reset");
    endtask

    // every time code, with a refused retrigger and a clock-enable stall on code 0
    task automatic t_conv_time();
        int n;
        int k;
        chan_en <= 3'h1;
        for (int c = 0; c < 8; c++) begin
            ct_sh <= 3'(c);
            seq_start();
            n = 0;
            k = 0;
            while (adc_run && k < 10000) begin
                if (ce) n++;
                trig <= (c == 0 && k == 12);
                ce <= !(c == 0 && k >= 25 && k < 28);
                @(posedge clk);
                k++;
            end
            chk(64'(n), 64'(CT_US[c]), "conversion length");
            repeat (3) @(posedge clk);
        end
        do_reset();
    endtask

    // direct results, then a bus-only pass reusing the held current
    task automatic t_direct();
        cal <= 15'h1000;
        shunt_v <= 20'h0012C;
        bus_v <= 20'h003E8;
        temp_v <= 20'h0004D;
        chan_en <= 3'h7;
        ct_sh <= 3'h0;
        seq_start();
        seq_end();
        exp_e = 64'd600000;
        exp_q = 64'd600;
        chk(64'(cur), 64'd600, "current");
        chk(64'(rail_v), 64'd1000, "bus");
        chk(64'(temp), 64'h4D, "temp");
        chk(64'(pow), 64'd600000, "power");
        chk(64'(energy), exp_e, "energy");
        chk(64'(charge), exp_q, "charge");
        chan_en <= 3'h2;
        bus_v <= 20'h007D0;
        shunt_v <= 20'h003E7;
        seq_start();
        seq_end();
        exp_e = exp_e + 64'd1200000;
        chk(64'(cur), 64'd600, "current held");
        chk(64'(pow), 64'd1200000, "power with old current");
        chk(64'(energy), exp_e, "energy");
        chk(64'(charge), exp_q, "charge without shunt");
    endtask

    // two-sample averaging over all channels
    task automatic t_avg();
        avg <= 4'h1;
        cal <= 15'h0800;
        shunt_v <= 20'h00064;
        bus_v <= 20'h003E8;
        temp_v <= 20'h00032;
        step_v <= 20'h00002;
        chan_en <= 3'h7;
        seq_start();
        repeat (200) @(posedge clk);
        chk(64'(cur), 64'd600, "current before last round");
        seq_end();
        exp_e = exp_e + 64'd100000 + 64'd102204;
        exp_q = exp_q + 64'd202;
        chk(64'(cur), 64'd101, "averaged current");
        chk(64'(rail_v), 64'd1001, "averaged bus");
        chk(64'(temp), 64'd51, "averaged temp");
        chk(64'(pow), 64'd101101, "power from averages");
        chk(64'(energy), exp_e, "energy per sample");
        chk(64'(charge), exp_q, "charge per sample");
        avg <= 4'h0;
        step_v <= '0;
    endtask

    // continuous loop runs with no gap until switched back to triggered
    task automatic t_cont();
        int n;
        n = 0;
        chan_en <= 3'h1;
        cont <= 1'b1;
        seq_start();
        for (int k = 0; k < 300; k++) begin
            @(posedge clk);
            n += int'(adc_run);
        end
        chk(64'(n), 64'd300, "continuous run");
        cont <= 1'b0;
        seq_end();
        chk(64'(adc_run), 64'h0, "stopped");
    endtask

    // zero scaling constant zeroes the derived results
    task automatic t_cal_zero();
        int n;
        n = 0;
        cal <= '0;
        chan_en <= 3'h7;
        ct_bus <= 3'h1;
        ct_tmp <= 3'h2;
        seq_start();
        // bus and temperature codes set their own times, back to back
        while (adc_run && n < 1000) begin
            n++;
            @(posedge clk);
        end
        chk(64'(n), 64'(CT_US[0] + CT_US[1] + CT_US[2]), "sequence length");
        seq_end();
        chk(64'(pow), 64'h0, "power");
        chk(64'(energy), 64'h0, "energy");
        chk(64'(charge), 64'h0, "charge");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        ce = 1'b1;
        cont = 1'b0;
        trig = 1'b0;
        chan_en = 3'h1;
        ct_sh = 3'h0;
        ct_bus = 3'h0;
        ct_tmp = 3'h0;
        avg = 4'h0;
        cal = 15'h0800;
        shunt_v = 20'h00010;
        bus_v = 20'h00010;
        temp_v = 20'h00010;
        step_v = '0;
        error_cnt = 0;
        n_compared = 0;
        cyc_cnt = 0;
        do_reset();
        t_reset_vals();
        t_conv_time();
        t_direct();
        t_avg();
        t_cont();
        t_cal_zero();
        tally_and_finish();
    end
endmodule

// ==== pwr_eng_pkg.sv ====
// shared constants, types and helpers of the measurement and calculation engine
package pwr_eng_pkg;

    // clock and conversion time table in microseconds
    localparam int CLK_PERIOD_NS = 20;
    localparam int NS_PER_US     = 1000;
    localparam int CT_US [8]     = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    localparam int TMR_W         = 18;

    // data path widths and scaling
    localparam int DATA_W       = 20;
    localparam int CAL_W        = 15;
    localparam int CAL_SHIFT    = 11;
    localparam int POW_W        = 2 * DATA_W + 1;
    localparam int ACCU_W       = 48;
    localparam int AVG_LOG2_MAX = 10;
    localparam int AVG_EXT_W    = AVG_LOG2_MAX;
    localparam int SUM_W        = DATA_W + AVG_EXT_W;
    localparam int ROUND_W      = AVG_LOG2_MAX + 1;

    // channel codes of the shared converter
    localparam logic [1:0] CH_SHUNT = 2'h0;
    localparam logic [1:0] CH_BUS   = 2'h1;
    localparam logic [1:0] CH_TEMP  = 2'h2;
    localparam logic [1:0] CH_NONE  = 2'h3;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } seq_state_type;

    // first enabled channel at or after start, none if no channel left
    function automatic logic [1:0] find_chan(input logic [1:0] start, input logic [2:0] en);
        logic [1:0] res;
        res = CH_NONE;
        for (int i = 2; i >= 0; i--) begin
            if (en[i] && (i >= int'(start)) && (start != CH_NONE)) begin
                res = 2'(i);
            end
        end
        return res;
    endfunction

endpackage
